// ### verilog/fmc_ctrl.v
// Flash memory controller: register file, command sequencer and protection handling
`timescale 1ns/100ps
`default_nettype none
`include "fmc_defines.vh"

module fmc_ctrl (
    input wire clk,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    output wire [7:0] sfr_rdata,
    output wire pc_hold,
    output wire irq_defer,
    output wire arr_req,
    output wire [1:0] arr_op,
    output wire [13:0] arr_addr,
    output wire [7:0] arr_wdata,
    input wire [7:0] arr_rdata,
    input wire arr_ack
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam S_BOOT = 2'h0;
localparam S_IDLE = 2'h1;
localparam S_REQ = 2'h2;
localparam S_WAIT = 2'h3;

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0] cmd_q;
reg [7:0] key_q;
reg [7:0] pkey_q;
reg [7:0] data_q;
reg [7:0] wep_low_q;
reg [7:0] wep_mid_q;
reg [7:0] rdp_q;
reg [7:0] alow_q;
reg [7:0] ahigh_q;
reg [7:0] rdata_q;
reg [1:0] state_q;
reg [7:0] op_q;
reg step_q;
reg [2:0] idx_q;
reg busy_q;
reg req_q;
reg [1:0] aop_q;
reg [13:0] aaddr_q;
reg [7:0] awdata_q;
reg [7:0] stored_key_q;
reg [31:0] we_eff_q;
reg [7:0] rd_eff_q;

wire [13:0] byte_addr;
wire we_ok;
wire all_ok;
wire rd_ok;
wire key_ok;
wire prot_ok;
wire cmd_wr;
wire img_wipe;
reg start_ok;

assign byte_addr = {ahigh_q[5:0], alow_q};
assign key_ok = (key_q == `FMC_ACCESS_KEY);
// Blank stored key means no comparison is made
assign prot_ok = (stored_key_q == `FMC_BLANK_KEY) || (pkey_q == stored_key_q);
// Command writes during boot or a running operation are dropped like any other write
assign cmd_wr = sfr_wr && (sfr_addr == `FMC_ADDR_CMD) && (state_q == S_IDLE);
// Mass erase or a top page erase blanks the stored image, so the live copy must follow
assign img_wipe = (state_q == S_WAIT) && arr_ack
    && ((aop_q == `FMC_OP_EALL) || ((aop_q == `FMC_OP_EPAGE) && (aaddr_q[13:9] == `FMC_TOP_PAGE)));

assign sfr_rdata = rdata_q;
// Both stall outputs share one flop so they can never disagree
assign pc_hold = busy_q;
assign irq_defer = busy_q;
assign arr_req = req_q;
assign arr_op = aop_q;
assign arr_addr = aaddr_q;
assign arr_wdata = awdata_q;

// ----------------------------------------------------------------
// Protection lookup
// ----------------------------------------------------------------
// Page index is the top five bits of the byte address
fmc_prot_check u_prot (
    .page(byte_addr[13:9]),
    .we_bits(we_eff_q),
    .rd_bits(rd_eff_q),
    .we_ok(we_ok),
    .all_ok(all_ok),
    .rd_ok(rd_ok)
);

// ----------------------------------------------------------------
// Command acceptance
// ----------------------------------------------------------------
// Refused commands still store the code and re-arm the key
always @* begin
    start_ok = 1'b0;
    if (key_ok) begin
        case (sfr_wdata)
            `FMC_CMD_WRITE: start_ok = we_ok;
            `FMC_CMD_EPAGE: start_ok = we_ok;
            `FMC_CMD_EALL: start_ok = all_ok;
            `FMC_CMD_READ: start_ok = rd_ok;
            `FMC_CMD_EWRITE: start_ok = we_ok;
            `FMC_CMD_PROTECT: start_ok = prot_ok;
            default: start_ok = 1'b0;
        endcase
    end
end

// Protection image byte for each slot of the storage area
function [7:0] prot_byte;
    input [2:0] idx;
    input [7:0] pkey;
    input [7:0] wl;
    input [7:0] wm;
    input [7:0] al;
    input [7:0] ah;
    input [7:0] rp;
    begin
        case (idx)
            3'h0: prot_byte = pkey;
            3'h1: prot_byte = wl;
            3'h2: prot_byte = wm;
            3'h3: prot_byte = al;
            3'h4: prot_byte = ah;
            default: prot_byte = rp;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// Register reads
// ----------------------------------------------------------------
// Read data is registered, so it follows the read strobe by one cycle
always @(posedge clk or posedge rst) begin
    if (rst) begin
        rdata_q <= 8'h00;
    end else if (sfr_rd) begin
        case (sfr_addr)
            `FMC_ADDR_CMD: rdata_q <= cmd_q;
            `FMC_ADDR_KEY: rdata_q <= key_q;
            `FMC_ADDR_PKEY: rdata_q <= pkey_q;
            `FMC_ADDR_DATA: rdata_q <= data_q;
            `FMC_ADDR_WEP_LOW: rdata_q <= wep_low_q;
            `FMC_ADDR_WEP_MID: rdata_q <= wep_mid_q;
            `FMC_ADDR_RDP: rdata_q <= rdp_q;
            `FMC_ADDR_ALOW: rdata_q <= alow_q;
            `FMC_ADDR_AHIGH: rdata_q <= ahigh_q;
            default: rdata_q <= 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
// Writes are ignored while busy; the core is stalled then anyway
always @(posedge clk or posedge rst) begin
    if (rst) begin
        cmd_q <= `FMC_RST_CMD;
        key_q <= `FMC_RST_KEY;
        pkey_q <= `FMC_RST_PKEY;
        wep_low_q <= `FMC_RST_PROT;
        wep_mid_q <= `FMC_RST_PROT;
        rdp_q <= `FMC_RST_PROT;
        alow_q <= `FMC_RST_ADDR;
        ahigh_q <= `FMC_RST_ADDR;
    end else if (sfr_wr && state_q == S_IDLE) begin
        case (sfr_addr)
            `FMC_ADDR_CMD: begin
                cmd_q <= sfr_wdata;
                key_q <= `FMC_RST_KEY;
            end
            `FMC_ADDR_KEY: key_q <= sfr_wdata;
            `FMC_ADDR_PKEY: pkey_q <= sfr_wdata;
            `FMC_ADDR_WEP_LOW: wep_low_q <= sfr_wdata;
            `FMC_ADDR_WEP_MID: wep_mid_q <= sfr_wdata;
            `FMC_ADDR_RDP: rdp_q <= sfr_wdata;
            `FMC_ADDR_ALOW: alow_q <= sfr_wdata;
            `FMC_ADDR_AHIGH: ahigh_q <= sfr_wdata;
            // Data register lives in the sequencer, which also loads it on reads
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
// After reset the protection image is read back from flash before any command
always @(posedge clk or posedge rst) begin
    if (rst) begin
        state_q <= S_BOOT;
        op_q <= `FMC_CMD_NONE;
        step_q <= 1'b0;
        idx_q <= 3'h0;
        busy_q <= 1'b1;
        req_q <= 1'b0;
        aop_q <= `FMC_OP_READ;
        aaddr_q <= 14'h0000;
        awdata_q <= 8'h00;
        data_q <= `FMC_RST_DATA;
        stored_key_q <= `FMC_BLANK_KEY;
        we_eff_q <= 32'hFFFFFFFF;
        rd_eff_q <= `FMC_RST_PROT;
    end else begin
        case (state_q)
            S_BOOT: begin
                op_q <= `FMC_CMD_NONE;
                idx_q <= 3'h0;
                state_q <= S_REQ;
            end
            S_IDLE: begin
                if (sfr_wr && sfr_addr == `FMC_ADDR_DATA) begin
                    data_q <= sfr_wdata;
                end
                if (cmd_wr && start_ok) begin
                    op_q <= sfr_wdata;
                    step_q <= 1'b0;
                    // Key slot is programmed only while still blank
                    idx_q <= (stored_key_q == `FMC_BLANK_KEY) ? 3'h0 : 3'h1;
                    busy_q <= 1'b1;
                    state_q <= S_REQ;
                end
            end
            S_REQ: begin
                req_q <= 1'b1;
                awdata_q <= data_q;
                aaddr_q <= byte_addr;
                case (op_q)
                    `FMC_CMD_NONE: begin
                        aop_q <= `FMC_OP_READ;
                        aaddr_q <= `FMC_PROT_BASE + {11'h000, idx_q};
                    end
                    `FMC_CMD_WRITE: aop_q <= `FMC_OP_PROG;
                    `FMC_CMD_EPAGE: aop_q <= `FMC_OP_EPAGE;
                    `FMC_CMD_EALL: aop_q <= `FMC_OP_EALL;
                    `FMC_CMD_READ: aop_q <= `FMC_OP_READ;
                    `FMC_CMD_EWRITE: aop_q <= step_q ? `FMC_OP_PROG : `FMC_OP_EPAGE;
                    `FMC_CMD_PROTECT: begin
                        aop_q <= `FMC_OP_PROG;
                        aaddr_q <= `FMC_PROT_BASE + {11'h000, idx_q};
                        awdata_q <= prot_byte(idx_q, pkey_q, wep_low_q, wep_mid_q,
                            alow_q, ahigh_q, rdp_q);
                    end
                    default: aop_q <= `FMC_OP_READ;
                endcase
                state_q <= S_WAIT;
            end
            S_WAIT: begin
                if (arr_ack) begin
                    req_q <= 1'b0;
                    state_q <= S_IDLE;
                    busy_q <= 1'b0;
                    case (op_q)
                        `FMC_CMD_NONE: begin
                            case (idx_q)
                                3'h0: stored_key_q <= arr_rdata;
                                3'h1: we_eff_q[7:0] <= arr_rdata;
                                3'h2: we_eff_q[15:8] <= arr_rdata;
                                3'h3: we_eff_q[23:16] <= arr_rdata;
                                3'h4: we_eff_q[31:24] <= arr_rdata;
                                default: rd_eff_q <= arr_rdata;
                            endcase
                            if (idx_q != `FMC_PROT_LAST) begin
                                idx_q <= idx_q + 3'h1;
                                busy_q <= 1'b1;
                                state_q <= S_REQ;
                            end
                        end
                        `FMC_CMD_READ: data_q <= arr_rdata;
                        `FMC_CMD_EWRITE: begin
                            if (!step_q) begin
                                step_q <= 1'b1;
                                busy_q <= 1'b1;
                                state_q <= S_REQ;
                            end
                        end
                        `FMC_CMD_PROTECT: begin
                            // Programming only clears bits, so the live image is ANDed
                            case (idx_q)
                                3'h0: stored_key_q <= pkey_q;
                                3'h1: we_eff_q[7:0] <= we_eff_q[7:0] & wep_low_q;
                                3'h2: we_eff_q[15:8] <= we_eff_q[15:8] & wep_mid_q;
                                3'h3: we_eff_q[23:16] <= we_eff_q[23:16] & alow_q;
                                3'h4: we_eff_q[31:24] <= we_eff_q[31:24] & ahigh_q;
                                default: rd_eff_q <= rd_eff_q & rdp_q;
                            endcase
                            if (idx_q != `FMC_PROT_LAST) begin
                                idx_q <= idx_q + 3'h1;
                                busy_q <= 1'b1;
                                state_q <= S_REQ;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            default: state_q <= S_IDLE;
        endcase
        // Erased image reads back blank; a byte program into the image waits for the next boot
        if (img_wipe) begin
            stored_key_q <= `FMC_BLANK_KEY;
            we_eff_q <= 32'hFFFFFFFF;
            rd_eff_q <= `FMC_RST_PROT;
        end
    end
end

endmodule

`default_nettype wire

// ### common/fmc_defines.vh
// Register map, command codes, array operations and reset values of the flash controller
`ifndef FMC_DEFINES_VH
`define FMC_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FMC_ADDR_CMD 8'hB9
`define FMC_ADDR_KEY 8'hBA
`define FMC_ADDR_PKEY 8'hBB
`define FMC_ADDR_DATA 8'hBC
`define FMC_ADDR_WEP_LOW 8'hBD
`define FMC_ADDR_WEP_MID 8'hBE
`define FMC_ADDR_RDP 8'hBF
`define FMC_ADDR_ALOW 8'hC6
`define FMC_ADDR_AHIGH 8'hC7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FMC_RST_CMD 8'h00
`define FMC_RST_KEY 8'hFF
`define FMC_RST_PKEY 8'hFF
`define FMC_RST_DATA 8'h00
`define FMC_RST_PROT 8'hFF
`define FMC_RST_ADDR 8'h00

// ----------------------------------------------------------------
// Access key and protection storage
// ----------------------------------------------------------------
`define FMC_ACCESS_KEY 8'h3B
`define FMC_BLANK_KEY 8'hFF
`define FMC_PROT_BASE 14'h3FFA
`define FMC_PROT_LAST 3'h5
`define FMC_PAGES 32
`define FMC_PAGE_BYTES 512
`define FMC_TOP_PAGE 5'h1F

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FMC_CMD_NONE 8'h00
`define FMC_CMD_WRITE 8'h01
`define FMC_CMD_EPAGE 8'h02
`define FMC_CMD_EALL 8'h03
`define FMC_CMD_READ 8'h04
`define FMC_CMD_EWRITE 8'h05
`define FMC_CMD_PROTECT 8'h08

// ----------------------------------------------------------------
// Array operations
// ----------------------------------------------------------------
`define FMC_OP_READ 2'h0
`define FMC_OP_PROG 2'h1
`define FMC_OP_EPAGE 2'h2
`define FMC_OP_EALL 2'h3

`endif

// ### verilog/fmc_prot_check.v
// Page protection lookup for write/erase and read access
`timescale 1ns/100ps
`default_nettype none

module fmc_prot_check (
    input wire [4:0] page,
    input wire [31:0] we_bits,
    input wire [7:0] rd_bits,
    output wire we_ok,
    output wire all_ok,
    output wire rd_ok
);

// ----------------------------------------------------------------
// Lookup
// ----------------------------------------------------------------
// A cleared bit means the page is protected
assign we_ok = we_bits[page];
// Mass erase is refused while any page is protected
assign all_ok = &we_bits;
// Read groups are four pages wide
assign rd_ok = rd_bits[page[4:2]];

endmodule

`default_nettype wire

// ### bench/fmc_ctrl_monitor.sv
// Port-level assertions for the flash memory controller
`timescale 1ns/100ps
`default_nettype none
module fmc_ctrl_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic pc_hold,
    input wire logic irq_defer,
    input wire logic arr_req,
    input wire logic [1:0] arr_op,
    input wire logic [13:0] arr_addr,
    input wire logic [7:0] arr_wdata,
    input wire logic [7:0] arr_rdata,
    input wire logic arr_ack
);
    default clocking mc @(posedge clk); endclocking
    default disable iff (rst);
    property p_defer; irq_defer == pc_hold; endproperty
    a_defer: assert property (p_defer) else $error("irq_defer differs from pc_hold");
    property p_req_hold; arr_req |-> pc_hold; endproperty
    a_req_hold: assert property (p_req_hold) else $error("array busy without pc_hold");
    property p_stable; arr_req && !arr_ack |=> arr_req && $stable(arr_op) && $stable(arr_addr)
        && $stable(arr_wdata); endproperty
    a_stable: assert property (p_stable) else $error("array request changed before ack");
    property p_gap; arr_req && arr_ack |=> !arr_req; endproperty
    a_gap: assert property (p_gap) else $error("array request kept after ack");
    property p_release; $fell(pc_hold) |-> $past(arr_ack); endproperty
    a_release: assert property (p_release) else $error("pc_hold dropped without ack");
    property p_start; $rose(pc_hold) |-> $past(sfr_wr) && $past(sfr_addr) == 8'hB9; endproperty
    a_start: assert property (p_start) else $error("pc_hold rose without command write");
    property p_launch; $rose(pc_hold) |-> ##[1:2] arr_req; endproperty
    a_launch: assert property (p_launch) else $error("no array request after hold");
    property p_refuse; sfr_wr && sfr_addr == 8'hB9 && !pc_hold && !(sfr_wdata inside {1, 2, 3, 4, 5, 8})
        |=> !pc_hold [*2]; endproperty
    a_refuse: assert property (p_refuse) else $error("undefined command started");
    property p_key_busy; sfr_rd && sfr_addr == 8'hBA && pc_hold |=> sfr_rdata == 8'hFF; endproperty
    a_key_busy: assert property (p_key_busy) else $error("key not rearmed while busy");
    property p_unmapped; sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### bench/fmc_flash_model.sv
// Behavioural flash array: 32 pages of 512 bytes, erased state all ones
`timescale 1ns/100ps
`default_nettype none
module fmc_flash_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire logic arr_req,
    input wire logic [1:0] arr_op,
    input wire logic [13:0] arr_addr,
    input wire logic [7:0] arr_wdata,
    output logic [7:0] arr_rdata,
    output logic arr_ack
);
    logic [7:0] mem [0:16383];
    logic [3:0] cnt;
    integer i;
    initial for (i = 0; i < 16384; i = i + 1) mem[i] = 8'hFF;
    // Read data is only valid with ack; otherwise it toggles so stale values never pass
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            arr_ack <= 1'b0;
            arr_rdata <= 8'h00;
        end else begin
            arr_ack <= 1'b0;
            arr_rdata <= ~arr_rdata;
            if (arr_req && !arr_ack) begin
                cnt <= cnt + 4'h1;
                if (cnt >= lat) begin
                    cnt <= 4'h0;
                    arr_ack <= 1'b1;
                    case (arr_op)
                        2'h0: arr_rdata <= mem[arr_addr];
                        2'h1: mem[arr_addr] = mem[arr_addr] & arr_wdata;
                        2'h2: for (i = 0; i < 512; i = i + 1) mem[{arr_addr[13:9], i[8:0]}] = 8'hFF;
                        default: for (i = 0; i < 16384; i = i + 1) mem[i] = 8'hFF;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/fmc_ctrl_tb.sv
// Self-checking testbench for the flash memory controller
`timescale 1ns/100ps
`default_nettype none
module fmc_ctrl_tb;
    logic clk, rst, sfr_wr, sfr_rd, arr_req, arr_ack, pc_hold, irq_defer;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, arr_wdata, arr_rdata, v;
    logic [1:0] arr_op;
    logic [13:0] arr_addr;
    logic [3:0] lat;
    integer bad_count, check_count, i;
    localparam logic [143:0] RT = {8'hB9, 8'h00, 8'hBA, 8'hFF, 8'hBB, 8'hFF, 8'hBC, 8'h00, 8'hBD, 8'hFF,
        8'hBE, 8'hFF, 8'hBF, 8'hFF, 8'hC6, 8'h00, 8'hC7, 8'h00};
    fmc_ctrl DUT (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pc_hold(pc_hold), .irq_defer(irq_defer), .arr_req(arr_req),
        .arr_op(arr_op), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_ack(arr_ack));
    fmc_flash_model fl (.clk(clk), .rst(rst), .lat(lat), .arr_req(arr_req), .arr_op(arr_op),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_ack(arr_ack));
    always #5 clk = ~clk;
    // ----------------------------------------
    // Register access and checking tasks
    // ----------------------------------------
    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD %s expected %h seen %h", n, exp, got);
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(negedge clk);
            sfr_addr = a;
            sfr_wdata = d;
            sfr_wr = 1'b1;
            @(negedge clk);
            sfr_wr = 1'b0;
        end
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        begin
            @(negedge clk);
            sfr_addr = a;
            sfr_rd = 1'b1;
            @(negedge clk);
            sfr_rd = 1'b0;
            d = sfr_rdata;
        end
    endtask
    // Core stalls on the command write; the key readback goes ahead, the next command waits for pc_hold to drop
    task idle;
        integer n;
        begin
            n = 0;
            while (pc_hold !== 1'b0 && n < 200) begin
                chk("defer", {7'h00, irq_defer}, 8'h01);
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 200) begin
                bad_count = bad_count + 1;
                close_out;
            end
        end
    endtask
    task cmd(input logic [7:0] ah, input logic [7:0] al, input logic [7:0] d, input logic [7:0] c,
        input logic [7:0] k);
        begin
            wr(8'hBC, d);
            wr(8'hC7, ah);
            wr(8'hC6, al);
            wr(8'hBA, k);
            wr(8'hB9, c);
            rd(8'hBA, v);
            chk("key", v, 8'hFF);
            idle;
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        lat = 4'h3;
        bad_count = 0;
        check_count = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 9; i = i + 1) begin
            rd(RT[143 - 16 * i -: 8], v);
            chk("reset", v, RT[135 - 16 * i -: 8]);
        end
        idle;
        rd(8'h00, v);
        chk("unmapped", v, 8'h00);
        cmd(8'h3C, 8'h00, 8'hF3, 8'h01, 8'h3B);
        chk("prog", fl.mem[14'h3C00], 8'hF3);
        rd(8'hB9, v);
        chk("cmdreg", v, 8'h01);
        lat = 4'h0;
        cmd(8'h3C, 8'h00, 8'h00, 8'h04, 8'h3B);
        rd(8'hBC, v);
        chk("read", v, 8'hF3);
        cmd(8'h3C, 8'h01, 8'h12, 8'h01, 8'h00);
        chk("nokey", fl.mem[14'h3C01], 8'hFF);
        cmd(8'h3C, 8'h01, 8'h12, 8'h06, 8'h3B);
        chk("undef", fl.mem[14'h3C01], 8'hFF);
        lat = 4'h7;
        cmd(8'h3C, 8'h01, 8'h0F, 8'h01, 8'h3B);
        cmd(8'h3D, 8'hFF, 8'h00, 8'h01, 8'h3B);
        cmd(8'h3C, 8'h01, 8'hF3, 8'h05, 8'h3B);
        chk("ewrite", fl.mem[14'h3C01], 8'hF3);
        chk("epage_end", fl.mem[14'h3DFF], 8'hFF);
        cmd(8'h3D, 8'h7F, 8'h00, 8'h02, 8'h3B);
        chk("epage", fl.mem[14'h3C01], 8'hFF);
        cmd(8'h00, 8'h00, 8'h00, 8'h01, 8'h3B);
        cmd(8'h00, 8'h00, 8'h00, 8'h03, 8'h3B);
        chk("eall", fl.mem[14'h0000], 8'hFF);
        wr(8'hBB, 8'hA5);
        wr(8'hBD, 8'hFE);
        rd(8'hBD, v);
        chk("we_low", v, 8'hFE);
        cmd(8'hFF, 8'h7F, 8'h00, 8'h08, 8'h3B);
        chk("keyslot", fl.mem[14'h3FFA], 8'hA5);
        chk("img_low", fl.mem[14'h3FFB], 8'hFE);
        chk("img_addr", fl.mem[14'h3FFD], 8'h7F);
        cmd(8'h00, 8'h00, 8'h00, 8'h01, 8'h3B);
        chk("prot0", fl.mem[14'h0000], 8'hFF);
        cmd(8'h2E, 8'h00, 8'h00, 8'h01, 8'h3B);
        chk("prot23", fl.mem[14'h2E00], 8'hFF);
        cmd(8'h02, 8'h00, 8'h00, 8'h01, 8'h3B);
        chk("open1", fl.mem[14'h0200], 8'h00);
        cmd(8'h00, 8'h00, 8'h00, 8'h03, 8'h3B);
        chk("eall_prot", fl.mem[14'h0200], 8'h00);
        wr(8'hBB, 8'h00);
        wr(8'hBE, 8'hFE);
        wr(8'hBF, 8'hFE);
        cmd(8'hFF, 8'hFF, 8'h00, 8'h08, 8'h3B);
        chk("badpkey", fl.mem[14'h3FFC], 8'hFF);
        wr(8'hBB, 8'hA5);
        cmd(8'hFF, 8'hFF, 8'h00, 8'h08, 8'h3B);
        chk("img_mid", fl.mem[14'h3FFC], 8'hFE);
        chk("img_rd", fl.mem[14'h3FFF], 8'hFE);
        cmd(8'h00, 8'h00, 8'h77, 8'h04, 8'h3B);
        rd(8'hBC, v);
        chk("rdprot", v, 8'h77);
        cmd(8'h08, 8'h00, 8'h00, 8'h04, 8'h3B);
        rd(8'hBC, v);
        chk("rdopen", v, 8'hFF);
        cmd(8'h3F, 8'h00, 8'h00, 8'h02, 8'h3B);
        chk("wipe", fl.mem[14'h3FFA], 8'hFF);
        cmd(8'h00, 8'h00, 8'h5A, 8'h01, 8'h3B);
        chk("unprot", fl.mem[14'h0000], 8'h5A);
        close_out;
    end
endmodule
bind fmc_ctrl fmc_ctrl_monitor u_mon (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pc_hold(pc_hold), .irq_defer(irq_defer),
    .arr_req(arr_req), .arr_op(arr_op), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
    .arr_ack(arr_ack));
`default_nettype wire
